// *** verilog/uart_evt_map.svh ***
// offsets, field positions and reset values of the event and interrupt register block
`ifndef UART_EVT_MAP_SVH
`define UART_EVT_MAP_SVH

// ************************************************************
// event indices inside the flag vector
// ************************************************************
`define EV_CTS_DEASSERTED  0
`define EV_BYTE_RECEIVED   1
`define EV_RXFULL      2
`define EV_BYTE_SENT   3
`define EV_TX_END      4
`define EV_ERROR       5
`define EV_RX_TIMEOUT  6
`define EV_RX_STARTED  7
`define EV_TX_STARTED  8
`define EV_TX_STOPPED  9
`define EV_COUNT       10

// ************************************************************
// register byte offsets
// ************************************************************
`define OFF_CTS_DEASSERTED  12'h104
`define OFF_BYTE_RECEIVED   12'h108
`define OFF_RX_BUFFER_FULL  12'h110
`define OFF_BYTE_SENT       12'h11C
`define OFF_TX_END          12'h120
`define OFF_ERROR           12'h124
`define OFF_RX_TIMEOUT      12'h144
`define OFF_RX_STARTED      12'h14C
`define OFF_TX_STARTED      12'h150
`define OFF_TX_STOPPED      12'h158
`define OFF_SHORTCUTS       12'h200
`define OFF_IRQ_ENABLE      12'h300

// ************************************************************
// field positions and reset values
// ************************************************************
`define FLAG_BIT             0
`define SHORT_RESTART_BIT    5
`define SHORT_STOP_BIT       6
`define IEN_BIT_CTS_DEASSERTED  1
`define IEN_BIT_BYTE_RECEIVED   2
`define IEN_BIT_RXFULL       4
`define IEN_BIT_BYTE_SENT    7
`define IEN_BIT_TX_END       8
`define IEN_BIT_ERROR        9
`define IEN_BIT_RX_TIMEOUT   17
`define IEN_BIT_RX_STARTED   19
`define IEN_BIT_TX_STARTED   20
`define IEN_BIT_TX_STOPPED   22
`define RESET_WORD           32'h0000_0000

`endif

// *** verilog/uart_evt_pkg.sv ***
// types shared by the event and interrupt register block
package uart_evt_pkg;
  `include "uart_evt_map.svh"

  typedef logic [`EV_COUNT-1:0] event_vec_type;
  typedef logic [31:0]          word_type;
  typedef logic [11:0]          addr_type;
endpackage

// *** verilog/event_flag.sv ***
// one sticky event flag with set-over-clear priority
`timescale 1ns/1ps

module event_flag (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  // set beats a clear in the same cycle so no event is lost
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      if (set_i) begin
        flag_o <= 1'b1;
      end else if (clr_i) begin
        flag_o <= 1'b0;
      end
    end
  end

endmodule

// *** verilog/uart_event_short_irq_regs.sv ***
// event flags, rx shortcuts and interrupt enables of the serial transceiver
`timescale 1ns/1ps
`include "uart_evt_map.svh"


module uart_event_short_irq_regs (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  ce_i,
  input  wire uart_evt_pkg::addr_type addr_i,
  input  wire uart_evt_pkg::word_type wdata_i,
  input  wire logic                  wr_stb_i,
  input  wire logic                  rd_stb_i,
  output uart_evt_pkg::word_type     rdata_o,
  input  wire logic                  cts_deasserted_i,
  input  wire logic                  byte_received_i,
  input  wire logic                  rx_buffer_full_i,
  input  wire logic                  byte_sent_i,
  input  wire logic                  tx_end_i,
  input  wire logic                  error_i,
  input  wire logic                  rx_timeout_i,
  input  wire logic                  rx_started_i,
  input  wire logic                  tx_started_i,
  input  wire logic                  tx_stopped_i,
  output logic                       rx_start_task_o,
  output logic                       rx_stop_task_o,
  output logic                       irq_o
);
  import uart_evt_pkg::*;

  // ************************************************************
  // decode helpers
  // ************************************************************

  // one-hot select of the event register hit by an address
  function automatic event_vec_type flag_select(input addr_type a);
    event_vec_type sel;
    sel = '0;
    case (a)
      `OFF_CTS_DEASSERTED: sel[`EV_CTS_DEASSERTED] = 1'b1;
      `OFF_BYTE_RECEIVED:  sel[`EV_BYTE_RECEIVED]  = 1'b1;
      `OFF_RX_BUFFER_FULL: sel[`EV_RXFULL]     = 1'b1;
      `OFF_BYTE_SENT:      sel[`EV_BYTE_SENT]  = 1'b1;
      `OFF_TX_END:         sel[`EV_TX_END]     = 1'b1;
      `OFF_ERROR:          sel[`EV_ERROR]      = 1'b1;
      `OFF_RX_TIMEOUT:     sel[`EV_RX_TIMEOUT] = 1'b1;
      `OFF_RX_STARTED:     sel[`EV_RX_STARTED] = 1'b1;
      `OFF_TX_STARTED:     sel[`EV_TX_STARTED] = 1'b1;
      `OFF_TX_STOPPED:     sel[`EV_TX_STOPPED] = 1'b1;
      default:             sel                 = '0;
    endcase
    return sel;
  endfunction

  // position of an event's enable bit inside the enable word
  function automatic int ien_bit(input int idx);
    int pos;
    pos = `IEN_BIT_CTS_DEASSERTED;
    case (idx)
      `EV_CTS_DEASSERTED: pos = `IEN_BIT_CTS_DEASSERTED;
      `EV_BYTE_RECEIVED:  pos = `IEN_BIT_BYTE_RECEIVED;
      `EV_RXFULL:     pos = `IEN_BIT_RXFULL;
      `EV_BYTE_SENT:  pos = `IEN_BIT_BYTE_SENT;
      `EV_TX_END:     pos = `IEN_BIT_TX_END;
      `EV_ERROR:      pos = `IEN_BIT_ERROR;
      `EV_RX_TIMEOUT: pos = `IEN_BIT_RX_TIMEOUT;
      `EV_RX_STARTED: pos = `IEN_BIT_RX_STARTED;
      `EV_TX_STARTED: pos = `IEN_BIT_TX_STARTED;
      `EV_TX_STOPPED: pos = `IEN_BIT_TX_STOPPED;
      default:        pos = `IEN_BIT_CTS_DEASSERTED;
    endcase
    return pos;
  endfunction

  // ************************************************************
  // event inputs and sticky flags
  // ************************************************************

  event_vec_type ev_in;
  event_vec_type flags;
  event_vec_type flag_clr;
  event_vec_type wr_sel;
  event_vec_type rd_sel;
  event_vec_type irq_mask;
  logic          restart_short;
  logic          stop_short;
  word_type      ien_word;
  word_type      next_rdata;

  // events come from the core on this clock, so no synchroniser
  assign ev_in[`EV_CTS_DEASSERTED] = cts_deasserted_i;
  assign ev_in[`EV_BYTE_RECEIVED]  = byte_received_i;
  assign ev_in[`EV_RXFULL]     = rx_buffer_full_i;
  assign ev_in[`EV_BYTE_SENT]  = byte_sent_i;
  assign ev_in[`EV_TX_END]     = tx_end_i;
  assign ev_in[`EV_ERROR]      = error_i;
  assign ev_in[`EV_RX_TIMEOUT] = rx_timeout_i;
  assign ev_in[`EV_RX_STARTED] = rx_started_i;
  assign ev_in[`EV_TX_STARTED] = tx_started_i;
  assign ev_in[`EV_TX_STOPPED] = tx_stopped_i;

  // a write of 0 in bit 0 clears only the addressed flag
  assign wr_sel   = flag_select(addr_i);
  assign rd_sel   = flag_select(addr_i);
  assign flag_clr = (wr_stb_i && !wdata_i[`FLAG_BIT]) ? wr_sel : '0;

  // one sticky flag per event
  genvar g;
  generate
    for (g = 0; g < `EV_COUNT; g++) begin : g_flag
      event_flag u_flag (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .ce_i       (ce_i),
        .set_i      (ev_in[g]),
        .clr_i      (flag_clr[g]),
        .flag_o     (flags[g])
      );
    end
  endgenerate

  // ************************************************************
  // shortcut and interrupt enable registers
  // ************************************************************

  // shortcut bits, cleared at reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      restart_short <= 1'b0;
      stop_short    <= 1'b0;
    end else if (ce_i && wr_stb_i && addr_i == `OFF_SHORTCUTS) begin
      restart_short <= wdata_i[`SHORT_RESTART_BIT];
      stop_short    <= wdata_i[`SHORT_STOP_BIT];
    end
  end

  // enables are kept packed by event index, unpacked on the bus
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_mask <= '0;
    end else if (ce_i && wr_stb_i && addr_i == `OFF_IRQ_ENABLE) begin
      for (int i = 0; i < `EV_COUNT; i++) begin
        irq_mask[i] <= wdata_i[ien_bit(i)];
      end
    end
  end

  // enable word as software sees it, unused bits zero
  always_comb begin
    ien_word = `RESET_WORD;
    for (int i = 0; i < `EV_COUNT; i++) begin
      ien_word[ien_bit(i)] = irq_mask[i];
    end
  end

  // ************************************************************
  // shortcut tasks and interrupt
  // ************************************************************

  // task pulses one cycle after the buffer-full event; both may fire together
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_start_task_o <= 1'b0;
      rx_stop_task_o  <= 1'b0;
    end else if (ce_i) begin
      rx_start_task_o <= rx_buffer_full_i && restart_short;
      rx_stop_task_o  <= rx_buffer_full_i && stop_short;
    end
  end

  // level interrupt straight from flags, so a clear drops it at once
  assign irq_o = |(flags & irq_mask);

  // ************************************************************
  // register read port
  // ************************************************************

  // read mux; flags read back in bit 0 only, unmapped reads zero
  always_comb begin
    next_rdata = `RESET_WORD;
    if (|rd_sel) begin
      next_rdata[`FLAG_BIT] = |(rd_sel & flags);
    end else if (addr_i == `OFF_SHORTCUTS) begin
      next_rdata[`SHORT_RESTART_BIT] = restart_short;
      next_rdata[`SHORT_STOP_BIT]    = stop_short;
    end else if (addr_i == `OFF_IRQ_ENABLE) begin
      next_rdata = ien_word;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_o <= `RESET_WORD;
    end else if (ce_i) begin
      rdata_o <= rd_stb_i ? next_rdata : `RESET_WORD;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // helper: flag of the flag register addressed in the previous cycle, read or not
  logic          rd_hit_q;
  logic          rd_flag_q;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_hit_q  <= 1'b0;
      rd_flag_q <= 1'b0;
    end else begin
      rd_hit_q  <= ce_i && rd_stb_i && (|rd_sel);
      rd_flag_q <= |(rd_sel & flags);
    end
  end

  property p_flag_read;
    rd_hit_q |-> rdata_o == {31'h0000_0000, rd_flag_q};
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("event register read shows wrong value");

  property p_byte_sent;
    ce_i && byte_sent_i |=> flags[`EV_BYTE_SENT];
  endproperty
  a_byte_sent: assert property (p_byte_sent)
    else $error("byte sent flag not set");

  property p_tx_end;
    ce_i && tx_end_i |=> flags[`EV_TX_END];
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("transmit end flag not set");

  property p_error;
    ce_i && error_i && wr_stb_i |=> flags[`EV_ERROR];
  endproperty
  a_error: assert property (p_error)
    else $error("error flag lost against a write");

  property p_rx_timeout;
    ce_i && rx_timeout_i |=> flags[`EV_RX_TIMEOUT];
  endproperty
  a_rx_timeout: assert property (p_rx_timeout)
    else $error("receiver timeout flag not set");

  property p_rx_started;
    ce_i && rx_started_i |=> flags[`EV_RX_STARTED];
  endproperty
  a_rx_started: assert property (p_rx_started)
    else $error("receive started flag not set");

  property p_tx_started;
    ce_i && tx_started_i |=> flags[`EV_TX_STARTED];
  endproperty
  a_tx_started: assert property (p_tx_started)
    else $error("transmit started flag not set");

  property p_tx_stopped;
    ce_i && tx_stopped_i |=> flags[`EV_TX_STOPPED];
  endproperty
  a_tx_stopped: assert property (p_tx_stopped)
    else $error("transmitter stopped flag not set");

  property p_restart;
    ce_i && rx_buffer_full_i |=> rx_start_task_o == $past(restart_short);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart shortcut task wrong");

  property p_stop;
    ce_i && rx_buffer_full_i |=> rx_stop_task_o == $past(stop_short);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop shortcut task wrong");

  property p_ien_write;
    ce_i && wr_stb_i && addr_i == `OFF_IRQ_ENABLE
      |=> irq_mask[`EV_ERROR] == $past(wdata_i[`IEN_BIT_ERROR]);
  endproperty
  a_ien_write: assert property (p_ien_write)
    else $error("interrupt enable write not taken");

  property p_ien_reset;
    $fell(reset_i) |-> !irq_mask[`EV_CTS_DEASSERTED] && !irq_mask[`EV_BYTE_RECEIVED];
  endproperty
  a_ien_reset: assert property (p_ien_reset)
    else $error("enables not off after reset");

  property p_ien_readback;
    ce_i && rd_stb_i && addr_i == `OFF_IRQ_ENABLE
      |=> rdata_o[`IEN_BIT_TX_STARTED] == $past(irq_mask[`EV_TX_STARTED]);
  endproperty
  a_ien_readback: assert property (p_ien_readback)
    else $error("enable readback wrong");

  property p_clear_one;
    ce_i && wr_stb_i && !wdata_i[`FLAG_BIT] && addr_i == `OFF_TX_END && !tx_end_i
      |=> !flags[`EV_TX_END] && flags[`EV_ERROR] == ($past(flags[`EV_ERROR]) || $past(error_i));
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("flag clear wrong or disturbed another flag");

  property p_flag_holds;
    flags[`EV_TX_STOPPED] && !(wr_stb_i && addr_i == `OFF_TX_STOPPED)
      |=> flags[`EV_TX_STOPPED];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag dropped without a clear");

  property p_irq;
    flags[`EV_BYTE_SENT] && irq_mask[`EV_BYTE_SENT] |-> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised for enabled flag");

  property p_irq_quiet;
    ce_i && wr_stb_i && addr_i == `OFF_IRQ_ENABLE && wdata_i == `RESET_WORD
      |=> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt high with all enables off");

endmodule

// *** sim/uart_event_source.sv ***
// behavioural model of the transceiver core that raises event pulses
`timescale 1ns/1ps

module uart_event_source (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic [9:0] req_i,
  input  wire logic [1:0] delay_i,
  output logic      [9:0] ev_o
);
  logic [9:0] pend;
  logic [1:0] cnt;

  // ************************************************************
  // event pulse generator
  // ************************************************************
  // answers at once or up to three cycles late, like a busy core would
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend <= '0;
      cnt  <= '0;
      ev_o <= '0;
    end else begin
      ev_o <= '0;  // pulses last one cycle only
      if (req_i != '0) begin
        if (delay_i == 2'h0) begin
          ev_o <= req_i;
        end else begin
          pend <= req_i;
          cnt  <= delay_i - 2'h1;
        end
      end else if (pend != '0) begin
        if (cnt == 2'h0) begin
          ev_o <= pend;
          pend <= '0;
        end else begin
          cnt <= cnt - 2'h1;
        end
      end
    end
  end
endmodule

// *** sim/uart_event_short_irq_regs_test.sv ***
// self-checking bench for the event, shortcut and interrupt register block
`timescale 1ns/1ps
`include "uart_evt_map.svh"

module uart_event_short_irq_regs_test;
  import uart_evt_pkg::*;
  logic          core_clk_i;
  logic          reset_i;
  logic          ce_i;
  addr_type      addr_i;
  word_type      wdata_i;
  logic          wr_stb_i;
  logic          rd_stb_i;
  word_type      rdata_o;
  event_vec_type req;
  logic [1:0]    dly;
  event_vec_type ev;
  logic          rx_start_task_o;
  logic          rx_stop_task_o;
  logic          irq_o;
  int            num_errors;
  int            total_checks;
  event_vec_type m_flag;
  word_type      m_ien;
  word_type      m_short;
  word_type      ien_mask;
  word_type      seen;
  localparam addr_type OFFS [10] = '{`OFF_CTS_DEASSERTED, `OFF_BYTE_RECEIVED,
    `OFF_RX_BUFFER_FULL, `OFF_BYTE_SENT, `OFF_TX_END, `OFF_ERROR, `OFF_RX_TIMEOUT,
    `OFF_RX_STARTED, `OFF_TX_STARTED, `OFF_TX_STOPPED};
  localparam int POS [10] = '{`IEN_BIT_CTS_DEASSERTED, `IEN_BIT_BYTE_RECEIVED,
    `IEN_BIT_RXFULL, `IEN_BIT_BYTE_SENT, `IEN_BIT_TX_END, `IEN_BIT_ERROR, `IEN_BIT_RX_TIMEOUT,
    `IEN_BIT_RX_STARTED, `IEN_BIT_TX_STARTED, `IEN_BIT_TX_STOPPED};
  localparam word_type SHORT_MASK = 32'h0000_0060;

  uart_event_source src (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req),
    .delay_i(dly), .ev_o(ev));

  uart_event_short_irq_regs dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .rdata_o(rdata_o), .cts_deasserted_i(ev[`EV_CTS_DEASSERTED]),
    .byte_received_i(ev[`EV_BYTE_RECEIVED]),
    .rx_buffer_full_i(ev[`EV_RXFULL]), .byte_sent_i(ev[`EV_BYTE_SENT]),
    .tx_end_i(ev[`EV_TX_END]), .error_i(ev[`EV_ERROR]), .rx_timeout_i(ev[`EV_RX_TIMEOUT]),
    .rx_started_i(ev[`EV_RX_STARTED]), .tx_started_i(ev[`EV_TX_STARTED]),
    .tx_stopped_i(ev[`EV_TX_STOPPED]), .rx_start_task_o(rx_start_task_o),
    .rx_stop_task_o(rx_stop_task_o), .irq_o(irq_o));

  // ************************************************************
  // model, compare and bus tasks
  // ************************************************************
  function automatic word_type exp_irq();
    logic r;
    r = 1'b0;
    for (int k = 0; k < 10; k++) begin
      r = r | (m_flag[k] & m_ien[POS[k]]);
    end
    return {31'h0, r};
  endfunction

  task automatic chk(input word_type s, input word_type e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input addr_type a, input word_type d);
    @(posedge core_clk_i);
    addr_i   <= a;
    wdata_i  <= d;
    wr_stb_i <= 1'b1;
    @(posedge core_clk_i);
    wr_stb_i <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input addr_type a, output word_type v);
    @(posedge core_clk_i);
    addr_i   <= a;
    rd_stb_i <= 1'b1;
    @(posedge core_clk_i);
    rd_stb_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  // ask the core model for one event, then check the cycle after it is taken
  task automatic fire(input int i);
    int n;
    @(posedge core_clk_i);
    req <= event_vec_type'(1) << i;
    dly <= 2'($urandom_range(3));
    @(posedge core_clk_i);
    req <= '0;
    n = 0;
    #1;
    while (ev == '0 && n < 8) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (ce_i) m_flag[i] = 1'b1;
    @(posedge core_clk_i);
    #1;
    chk({31'h0, rx_start_task_o},
        {31'h0, ce_i & (i == `EV_RXFULL) & m_short[`SHORT_RESTART_BIT]});
    chk({31'h0, rx_stop_task_o},
        {31'h0, ce_i & (i == `EV_RXFULL) & m_short[`SHORT_STOP_BIT]});
    chk({31'h0, irq_o}, exp_irq());
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // clock and watchdog
  // ************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // the whole run needs well under a thousand cycles; this is ten thousand, far beyond it
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seen = $urandom(32'h4d27);
    {reset_i, ce_i, addr_i, wdata_i, wr_stb_i, rd_stb_i} = {2'b11, 12'h0, 32'h0, 2'b00};
    req = '0;
    dly = 2'h0;
    m_flag = '0;
    m_ien = '0;
    m_short = '0;
    ien_mask = '0;
    for (int k = 0; k < 10; k++) ien_mask[POS[k]] = 1'b1;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // everything clear after reset, unmapped place reads zero
    for (int k = 0; k < 10; k++) begin
      rd(OFFS[k], seen);
      chk(seen, 32'h0);
    end
    rd(`OFF_SHORTCUTS, seen);
    chk(seen, 32'h0);
    rd(`OFF_IRQ_ENABLE, seen);
    chk(seen, 32'h0);
    rd(12'h004, seen);
    chk(seen, 32'h0);
    // every event sets its own flag; writing ones neither clears nor widens it
    for (int k = 0; k < 10; k++) begin
      fire(k);
      wr(OFFS[k], 32'hFFFF_FFFF);
      rd(OFFS[k], seen);
      chk(seen, 32'h1);
      @(posedge core_clk_i);
      #1;
      chk(rdata_o, 32'h0);
    end
    // clearing one flag leaves every other one alone
    for (int k = 0; k < 10; k++) begin
      wr(OFFS[k], 32'hFFFF_FFFE);
      m_flag[k] = 1'b0;
      for (int j = 0; j < 10; j++) begin
        rd(OFFS[j], seen);
        chk(seen, {31'h0, m_flag[j]});
      end
    end
    // each enable bit gates only its own event onto the interrupt line
    for (int k = 0; k < 10; k++) begin
      m_ien = $urandom & ~(32'h1 << POS[k]);
      wr(`OFF_IRQ_ENABLE, m_ien);
      m_ien = m_ien & ien_mask;
      rd(`OFF_IRQ_ENABLE, seen);
      chk(seen, m_ien);
      fire(k);
      chk({31'h0, irq_o}, 32'h0);
      m_ien = m_ien | (32'h1 << POS[k]);
      wr(`OFF_IRQ_ENABLE, m_ien);
      chk({31'h0, irq_o}, 32'h1);
      wr(OFFS[k], 32'h0);
      m_flag[k] = 1'b0;
      chk({31'h0, irq_o}, 32'h0);
    end
    // all four shortcut settings, with an unrelated event as a decoy
    for (int s = 0; s < 4; s++) begin
      m_short = ($urandom & ~SHORT_MASK) | (word_type'(s) << `SHORT_RESTART_BIT);
      wr(`OFF_SHORTCUTS, m_short);
      m_short = m_short & SHORT_MASK;
      rd(`OFF_SHORTCUTS, seen);
      chk(seen, m_short);
      fire(`EV_RXFULL);
      fire(`EV_ERROR);
      wr(OFFS[`EV_RXFULL], 32'h0);
      wr(OFFS[`EV_ERROR], 32'h0);
      m_flag = '0;
    end
    // an event and a clear of the same flag in one cycle: the event wins
    @(posedge core_clk_i);
    req <= event_vec_type'(1) << `EV_ERROR;
    dly <= 2'h0;
    @(posedge core_clk_i);
    req      <= '0;
    addr_i   <= `OFF_ERROR;
    wdata_i  <= 32'h0;
    wr_stb_i <= 1'b1;
    @(posedge core_clk_i);
    wr_stb_i <= 1'b0;
    rd(`OFF_ERROR, seen);
    chk(seen, 32'h1);
    wr(`OFF_IRQ_ENABLE, 32'h0);
    m_ien = '0;
    chk({31'h0, irq_o}, 32'h0);
    wr(`OFF_ERROR, 32'h0);
    // with the clock enable low an event and a bus write are lost
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    wr(`OFF_SHORTCUTS, 32'h0);
    fire(`EV_TX_END);
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    rd(`OFF_TX_END, seen);
    chk(seen, 32'h0);
    rd(`OFF_SHORTCUTS, seen);
    chk(seen, m_short);
    report_and_stop();
  end
endmodule
